/* File: core/scp_pkg.sv */
// Summary of operation
// - Fuse code 0011 selects 128 kHz oscillator.
// - 128 kHz: 6 CK wake, 14CK plus delay.
// - Fuse code 0100 selects watch crystal.
// - Watch crystal: 1K or 32K CK wake.
// - Upper three select bits give crystal band.
// - Crystal: option bit plus startup code table.
// - Output fuse drives clock onto pin.
// - No clock on pin during reset.
// - Pin carries the divided system clock for codes 1 to 8, half of it at code 0.
// - All four domains share one divided clock.
// - Divider changes produce no short periods.
// - New rate active from the next tick of the old rate.
// - Reset loads factory trim, software may rewrite.
// - Trim top bit picks frequency band.
// - Low trim bits tune within band.
// - Unlock sets only on write of 0x80.
// - Unlock clears after four cycles or a prescale write with bit 7 clear.
// - Divider resets to 0 or divide-by-eight.
// - Unlocked writes accept divider codes 0 to 8 only.
// - Divider codes 0 to 8 divide by 2^n.
// - Fuse code 0000 selects external clock.
package scp_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_PRESCALE = 8'h28;
    localparam logic [7:0] ADDR_TRIM = 8'h2C;
    localparam logic [7:0] ADDR_STATUS = 8'h30;
    // Prescale register fields and reset values.
    localparam int PRESC_UNLOCK_BIT = 7;
    localparam logic [7:0] PRESC_UNLOCK_PATTERN = 8'h80;
    localparam logic [3:0] PRESC_DIV_RST_PLAIN = 4'h0;
    localparam logic [3:0] PRESC_DIV_RST_DIV8 = 4'h3;
    localparam logic [3:0] PRESC_DIV_CODE_MAX = 4'h8;
    localparam logic [2:0] UNLOCK_WINDOW = 3'h4;
    // Status register field positions.
    localparam int STAT_SRC_LSB = 0;
    localparam int STAT_DONE_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_BAND_LSB = 8;
    localparam int STAT_DIV_LSB = 12;
    // Clock source fuse codes.
    localparam logic [3:0] SRC_CODE_EXT = 4'h0;
    localparam logic [3:0] SRC_CODE_PLL = 4'h1;
    localparam logic [3:0] SRC_CODE_RC8 = 4'h2;
    localparam logic [3:0] SRC_CODE_RC128 = 4'h3;
    localparam logic [1:0] SRC_PREFIX_LFXTAL = 2'h1;
    typedef enum logic [2:0] {
        SRC_EXT, SRC_PLL, SRC_RC8, SRC_RC128, SRC_LFXTAL, SRC_XTAL
    } scp_src_t;
    // Start-up timing.
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_4MS_NS = 4000000;
    localparam int T_4P1MS_NS = 4100000;
    localparam int T_64MS_NS = 64000000;
    localparam int T_65MS_NS = 65000000;
    localparam logic [20:0] CK_14 = 21'h0000E;
    localparam logic [20:0] CK_6 = 21'h00006;
    localparam logic [20:0] CK_258 = 21'h00102;
    localparam logic [20:0] CK_1K = 21'h00400;
    localparam int CK_16K = 16384;
    localparam int CK_32K = 32768;
endpackage

/* File: core/scp_clock_ctrl.sv */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module scp_clock_ctrl #(
    parameter int DLY_4MS_CYC = scp_pkg::T_4MS_NS / scp_pkg::CLK_PERIOD_NS,
    parameter int DLY_4P1MS_CYC = scp_pkg::T_4P1MS_NS / scp_pkg::CLK_PERIOD_NS,
    parameter int DLY_64MS_CYC = scp_pkg::T_64MS_NS / scp_pkg::CLK_PERIOD_NS,
    parameter int DLY_65MS_CYC = scp_pkg::T_65MS_NS / scp_pkg::CLK_PERIOD_NS,
    parameter int CK_16K_CYC = scp_pkg::CK_16K,
    parameter int CK_32K_CYC = scp_pkg::CK_32K
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Fuses, zero means programmed
    input wire logic [3:0] clockSourceSelectFuses,
    input wire logic [1:0] startupTimeFuses,
    input wire logic clockOutputFuseN,
    input wire logic initialDivideByEightFuseN,
    input wire logic [7:0] factoryTrim,
    // Wake from power-down
    input wire logic wakeReq,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Source decode and trim
    output scp_pkg::scp_src_t clockSource,
    output logic [2:0] crystalBandSelect,
    output logic trimBandBit,
    output logic [6:0] trimFineBits,
    // Clock domain enables
    output logic ioClkEn,
    output logic adcClkEn,
    output logic cpuClkEn,
    output logic flashClkEn,
    output logic startupDone,
    // Clock output pin
    output logic clockOutputPin,
    output logic clockOutputOe,
    output logic gpioOverride
);
    import scp_pkg::*;

    typedef struct packed {
        logic [3:0] srcCode;
        logic [1:0] sutCode;
        scp_src_t srcKind;
        logic clkOutEn;
        logic [20:0] startCnt;
        logic startDone;
        logic [3:0] divSel;
        logic [3:0] divActive;
        logic divPend;
        logic divBusy;
        logic [7:0] divCnt;
        logic pinLvl;
        logic unlock;
        logic [2:0] unlockCnt;
        logic [7:0] trim;
        logic [31:0] rdata;
    } scp_state_t;

    scp_state_t st_r;
    scp_state_t st_nxt;

    function automatic logic [20:0] cyc(input int n);
        cyc = n[20:0];
    endfunction

    function automatic logic [7:0] divMask(input logic [3:0] code);
        logic [8:0] full;
        full = 9'h001 << code;
        divMask = 8'(full - 9'h001);
    endfunction

    function automatic scp_src_t srcDecode(input logic [3:0] code);
        case (code)
            SRC_CODE_EXT: srcDecode = SRC_EXT;
            SRC_CODE_PLL: srcDecode = SRC_PLL;
            SRC_CODE_RC8: srcDecode = SRC_RC8;
            SRC_CODE_RC128: srcDecode = SRC_RC128;
            default: srcDecode = code[3] ? SRC_XTAL : SRC_LFXTAL;
        endcase
    endfunction

    // Reserved start-up codes fall back to the longest delay of the family.
    function automatic logic [20:0] resetCount(input logic [3:0] src, input logic [1:0] startup_time_fuses);
        logic [2:0] idx;
        idx = {src[0], startup_time_fuses};
        resetCount = CK_14 + cyc(DLY_64MS_CYC);
        if (src[3])
        begin
            case (idx)
                3'h0: resetCount = CK_14 + cyc(DLY_4P1MS_CYC);
                3'h1: resetCount = CK_14 + cyc(DLY_65MS_CYC);
                3'h2: resetCount = CK_14;
                3'h3: resetCount = CK_14 + cyc(DLY_4P1MS_CYC);
                3'h4: resetCount = CK_14 + cyc(DLY_65MS_CYC);
                3'h5: resetCount = CK_14;
                3'h6: resetCount = CK_14 + cyc(DLY_4P1MS_CYC);
                default: resetCount = CK_14 + cyc(DLY_65MS_CYC);
            endcase
        end
        else if (src[3:2] == SRC_PREFIX_LFXTAL)
        begin
            case (startup_time_fuses)
                2'h0: resetCount = CK_1K + cyc(DLY_4MS_CYC);
                2'h1: resetCount = CK_1K + cyc(DLY_64MS_CYC);
                default: resetCount = cyc(CK_32K_CYC) + cyc(DLY_64MS_CYC);
            endcase
        end
        else
        begin
            case (startup_time_fuses)
                2'h0: resetCount = CK_14;
                2'h1: resetCount = CK_14 + cyc(DLY_4MS_CYC);
                default: resetCount = CK_14 + cyc(DLY_64MS_CYC);
            endcase
        end
    endfunction

    function automatic logic [20:0] wakeCount(input logic [3:0] src, input logic [1:0] startup_time_fuses);
        logic [2:0] idx;
        idx = {src[0], startup_time_fuses};
        wakeCount = CK_6;
        if (src[3])
        begin
            wakeCount = (idx <= 3'h1) ? CK_258 : ((idx <= 3'h4) ? CK_1K : cyc(CK_16K_CYC));
        end
        else if (src[3:2] == SRC_PREFIX_LFXTAL)
        begin
            wakeCount = (startup_time_fuses[1]) ? cyc(CK_32K_CYC) : CK_1K;
        end
    endfunction

    logic setupPhase;
    logic wrAccess;
    logic tick;
    logic [7:0] curMask;
    logic [7:0] newMask;

    assign setupPhase = psel && !penable;
    assign wrAccess = psel && penable && pwrite;
    assign curMask = divMask(st_r.divActive);
    assign tick = (st_r.divCnt == curMask);

    always_comb
    begin
        st_nxt = st_r;
        newMask = curMask;
        if (sys_rst)
        begin
            st_nxt.srcCode = clockSourceSelectFuses;
            st_nxt.sutCode = startupTimeFuses;
            st_nxt.srcKind = srcDecode(clockSourceSelectFuses);
            st_nxt.clkOutEn = !clockOutputFuseN;
            st_nxt.startCnt = resetCount(clockSourceSelectFuses, startupTimeFuses);
            st_nxt.startDone = 1'b0;
            st_nxt.divSel = initialDivideByEightFuseN ? PRESC_DIV_RST_PLAIN : PRESC_DIV_RST_DIV8;
            st_nxt.divActive = st_nxt.divSel;
            st_nxt.divPend = 1'b0;
            st_nxt.divBusy = 1'b0;
            st_nxt.divCnt = 8'h00;
            st_nxt.pinLvl = 1'b0;
            st_nxt.unlock = 1'b0;
            st_nxt.unlockCnt = 3'h0;
            st_nxt.trim = factoryTrim;
            st_nxt.rdata = 32'h00000000;
        end
        else
        begin
            if (!st_r.startDone)
            begin
                if (st_r.startCnt == 21'h000000)
                    st_nxt.startDone = 1'b1;
                else
                    st_nxt.startCnt = st_r.startCnt - 21'h000001;
            end
            else if (wakeReq)
            begin
                st_nxt.startDone = 1'b0;
                st_nxt.startCnt = wakeCount(st_r.srcCode, st_r.sutCode);
            end

            if (st_r.unlock)
            begin
                if (st_r.unlockCnt == 3'h1)
                    st_nxt.unlock = 1'b0;
                st_nxt.unlockCnt = st_r.unlockCnt - 3'h1;
            end

            if (tick)
            begin
                st_nxt.divCnt = 8'h00;
                if (st_r.divPend)
                begin
                    st_nxt.divActive = st_r.divSel;
                    st_nxt.divPend = 1'b0;
                end
                else
                    st_nxt.divBusy = 1'b0;
            end
            else
                st_nxt.divCnt = st_r.divCnt + 8'h01;
            newMask = divMask(st_nxt.divActive);
            st_nxt.pinLvl = (newMask == 8'h00) ? !st_r.pinLvl : (st_nxt.divCnt <= (newMask >> 1));

            if (wrAccess && paddr == ADDR_PRESCALE)
            begin
                if (pwdata[PRESC_UNLOCK_BIT])
                begin
                    if (pwdata[7:0] == PRESC_UNLOCK_PATTERN && !st_r.unlock)
                    begin
                        st_nxt.unlock = 1'b1;
                        st_nxt.unlockCnt = UNLOCK_WINDOW;
                    end
                end
                else if (st_r.unlock)
                begin
                    st_nxt.unlock = 1'b0;
                    st_nxt.unlockCnt = 3'h0;
                    if (pwdata[3:0] <= PRESC_DIV_CODE_MAX)
                    begin
                        st_nxt.divSel = pwdata[3:0];
                        st_nxt.divPend = 1'b1;
                        st_nxt.divBusy = 1'b1;
                    end
                end
            end
            if (wrAccess && paddr == ADDR_TRIM)
                st_nxt.trim = pwdata[7:0];

            if (setupPhase && !pwrite)
            begin
                st_nxt.rdata = 32'h00000000;
                case (paddr)
                    ADDR_PRESCALE:
                    begin
                        st_nxt.rdata[PRESC_UNLOCK_BIT] = st_r.unlock;
                        st_nxt.rdata[3:0] = st_r.divSel;
                    end
                    ADDR_TRIM: st_nxt.rdata[7:0] = st_r.trim;
                    ADDR_STATUS:
                    begin
                        st_nxt.rdata[STAT_SRC_LSB +: 3] = st_r.srcKind;
                        st_nxt.rdata[STAT_DONE_BIT] = st_r.startDone;
                        st_nxt.rdata[STAT_BUSY_BIT] = st_r.divBusy;
                        st_nxt.rdata[STAT_BAND_LSB +: 3] = st_r.srcCode[3:1];
                        st_nxt.rdata[STAT_DIV_LSB +: 4] = st_r.divActive;
                    end
                    default: st_nxt.rdata = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        st_r <= st_nxt;
    end

    // Zero wait states; read data was captured in the setup cycle.
    assign pready = psel && penable;
    assign pslverr = psel && penable && (paddr != ADDR_PRESCALE) && (paddr != ADDR_TRIM)
                     && (paddr != ADDR_STATUS);
    assign prdata = st_r.rdata;

    assign clockSource = st_r.srcKind;
    assign crystalBandSelect = (st_r.srcKind == SRC_XTAL) ? st_r.srcCode[3:1] : 3'h0;
    assign trimBandBit = st_r.trim[7];
    assign trimFineBits = st_r.trim[6:0];

    assign ioClkEn = tick && st_r.startDone;
    assign adcClkEn = tick && st_r.startDone;
    assign cpuClkEn = tick && st_r.startDone;
    assign flashClkEn = tick && st_r.startDone;
    assign startupDone = st_r.startDone;

    assign clockOutputOe = st_r.clkOutEn && !sys_rst;
    assign clockOutputPin = st_r.pinLvl && clockOutputOe;
    assign gpioOverride = st_r.clkOutEn;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    property p_src_rc128;
        (st_r.srcCode == SRC_CODE_RC128) |-> (clockSource == SRC_RC128);
    endproperty
    a_src_rc128: assert property (p_src_rc128)
        else $error("Code 0011 did not select the 128 kHz source.");

    property p_src_lfxtal;
        (st_r.srcCode[3:2] == SRC_PREFIX_LFXTAL) |-> (clockSource == SRC_LFXTAL);
    endproperty
    a_src_lfxtal: assert property (p_src_lfxtal)
        else $error("Code 01xx did not select the watch crystal.");

    property p_src_ext;
        (st_r.srcCode == SRC_CODE_EXT) |-> (clockSource == SRC_EXT);
    endproperty
    a_src_ext: assert property (p_src_ext)
        else $error("Code 0000 did not select the external clock.");

    property p_pin_reset;
        disable iff (1'b0) sys_rst |-> !clockOutputOe && !clockOutputPin;
    endproperty
    a_pin_reset: assert property (p_pin_reset)
        else $error("Clock pin driven during reset.");

    property p_unlock_source;
        $rose(st_r.unlock) |-> $past(wrAccess && paddr == ADDR_PRESCALE
                                     && pwdata[7:0] == PRESC_UNLOCK_PATTERN);
    endproperty
    a_unlock_source: assert property (p_unlock_source)
        else $error("Unlock set without a clean unlock write.");

    property p_unlock_window;
        $rose(st_r.unlock) |-> ##4 !st_r.unlock;
    endproperty
    a_unlock_window: assert property (p_unlock_window)
        else $error("Unlock bit outlived its four-cycle window.");

    property p_div_legal;
        (st_r.divSel <= PRESC_DIV_CODE_MAX) && (st_r.divActive <= PRESC_DIV_CODE_MAX);
    endproperty
    a_div_legal: assert property (p_div_legal)
        else $error("Reserved divider code became active.");

    property p_div_reset;
        $fell(sys_rst) |-> st_r.divSel == ($past(initialDivideByEightFuseN)
                                          ? PRESC_DIV_RST_PLAIN : PRESC_DIV_RST_DIV8);
    endproperty
    a_div_reset: assert property (p_div_reset)
        else $error("Divider reset value does not follow the fuse.");

    property p_domains_equal;
        (ioClkEn == adcClkEn) && (ioClkEn == cpuClkEn) && (ioClkEn == flashClkEn)
        && (st_r.startDone || !ioClkEn);
    endproperty
    a_domains_equal: assert property (p_domains_equal)
        else $error("Clock domains disagree or run before start-up.");

    property p_trim_load;
        $fell(sys_rst) |-> st_r.trim == $past(factoryTrim);
    endproperty
    a_trim_load: assert property (p_trim_load)
        else $error("Factory trim not loaded at reset.");

    property p_switch_edge;
        (st_r.divActive != $past(st_r.divActive)) |-> $past(tick) && st_r.divCnt == 8'h00;
    endproperty
    a_switch_edge: assert property (p_switch_edge)
        else $error("Divider switched in mid-period.");

    c_div_change: cover property ($rose(st_r.unlock) ##[1:4] $rose(st_r.divPend));
    c_start_done: cover property ($rose(st_r.startDone));
    c_reserved_write: cover property (st_r.unlock && wrAccess && paddr == ADDR_PRESCALE
                                      && !pwdata[7] && pwdata[3:0] > PRESC_DIV_CODE_MAX);
    c_pin_driven: cover property (clockOutputOe && st_r.divActive == 4'h3);
endmodule

/* File: test/scp_clk_sink.sv */
`timescale 1ns/1ps
module scp_clk_sink (
    // Clock and control
    input wire logic sys_clk,
    input wire logic clear,
    // Clock output pin
    input wire logic pin,
    input wire logic oe,
    // Observed rising edges
    output int edgeCount
);
    logic lineLvl;
    logic lastLvl;
    // The board pulls the released pin low, so an undriven line reads 0.
    assign lineLvl = oe ? pin : 1'b0;
    always_ff @(posedge sys_clk)
    begin
        lastLvl <= lineLvl;
        if (clear)
            edgeCount <= 0;
        else if (lineLvl && !lastLvl)
            edgeCount <= edgeCount + 1;
    end
endmodule

/* File: test/system_clock_source_and_prescaler_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checkCount++; \
        if ((got) !== (exp)) \
        begin \
            errorCnt++; \
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
        end \
    end
module system_clock_source_and_prescaler_tb;
    import scp_pkg::*;
    logic sys_clk = 0, sys_rst = 1, clockOutputFuseN = 0, initialDivideByEightFuseN = 0;
    logic [3:0] clockSourceSelectFuses = 4'h0;
    logic [1:0] startupTimeFuses = 2'h0;
    logic [7:0] factoryTrim = 8'h5A, paddr = 8'h00;
    logic wakeReq = 0, psel = 0, penable = 0, pwrite = 0, sinkClear = 0;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, trimBandBit, ioClkEn, adcClkEn, cpuClkEn, flashClkEn;
    logic startupDone, clockOutputPin, clockOutputOe, gpioOverride, errv;
    scp_src_t clockSource;
    logic [2:0] crystalBandSelect;
    logic [6:0] trimFineBits;
    int errorCnt = 0, checkCount = 0, cycles = 0, sinkEdges;
    scp_clock_ctrl #(.DLY_4MS_CYC(20), .DLY_4P1MS_CYC(20), .DLY_64MS_CYC(20),
        .DLY_65MS_CYC(20), .CK_16K_CYC(20), .CK_32K_CYC(20)) DUT (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .clockSourceSelectFuses(clockSourceSelectFuses),
        .startupTimeFuses(startupTimeFuses), .clockOutputFuseN(clockOutputFuseN),
        .initialDivideByEightFuseN(initialDivideByEightFuseN), .factoryTrim(factoryTrim),
        .wakeReq(wakeReq), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clockSource(clockSource), .crystalBandSelect(crystalBandSelect),
        .trimBandBit(trimBandBit), .trimFineBits(trimFineBits), .ioClkEn(ioClkEn),
        .adcClkEn(adcClkEn), .cpuClkEn(cpuClkEn), .flashClkEn(flashClkEn),
        .startupDone(startupDone), .clockOutputPin(clockOutputPin),
        .clockOutputOe(clockOutputOe), .gpioOverride(gpioOverride));
    scp_clk_sink sink (.sys_clk(sys_clk), .clear(sinkClear), .pin(clockOutputPin),
        .oe(clockOutputOe), .edgeCount(sinkEdges));
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // The longest reset wait is about 1045 cycles, so this leaves a wide margin.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errorCnt++;
            end_of_test();
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdv)
    endtask
    task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic d8,
            input logic co, output int n);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        clockSourceSelectFuses <= s;
        startupTimeFuses <= t;
        initialDivideByEightFuseN <= d8;
        clockOutputFuseN <= co;
        factoryTrim <= factoryTrim + 8'h11;
        repeat (20) @(posedge sys_clk);
        #1;
        `CHK("oe in reset", 1'b0, clockOutputOe)
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        n = 0;
        while (startupDone !== 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    task automatic wake(output int n);
        @(posedge sys_clk);
        wakeReq <= 1'b1;
        @(posedge sys_clk);
        wakeReq <= 1'b0;
        #1;
        n = 0;
        while (startupDone !== 1'b1)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask
    task automatic t_decode();
        logic [3:0] s[5] = '{4'h3, 4'h3, 4'h4, 4'hD, 4'h0};
        logic [1:0] t[5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h0};
        logic d8[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
        scp_src_t es[5] = '{SRC_RC128, SRC_RC128, SRC_LFXTAL, SRC_XTAL, SRC_EXT};
        logic [2:0] eb[5] = '{3'h0, 3'h0, 3'h0, 3'h6, 3'h0};
        int ec[5] = '{15, 35, 1045, 15, 15};
        int ew[5] = '{7, 7, 1025, 21, 7};
        logic co[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        int n;
        for (int i = 0; i < 5; i++)
        begin
            do_reset(s[i], t[i], d8[i], co[i], n);
            `CHK("gpio override", !co[i], gpioOverride)
            `CHK("pin enable", !co[i], clockOutputOe)
            `CHK("source", es[i], clockSource)
            `CHK("band", eb[i], crystalBandSelect)
            `CHK("startup cycles", ec[i], n)
            rd_chk(ADDR_PRESCALE, d8[i] ? 32'h0 : 32'h3, "prescale reset");
            rd_chk(ADDR_TRIM, {24'h0, factoryTrim}, "trim reset");
            rd_chk(ADDR_STATUS, {16'h0, (d8[i] ? 4'h0 : 4'h3), 1'b0, s[i][3:1], 3'h0, 2'h1,
                es[i]}, "status");
            wake(n);
            `CHK("wake cycles", ew[i], n)
        end
    endtask
    task automatic t_unlock();
        apb(1'b1, ADDR_PRESCALE, 32'h81);
        rd_chk(ADDR_PRESCALE, 32'h3, "no unlock");
        apb(1'b1, ADDR_PRESCALE, 32'h80);
        rd_chk(ADDR_PRESCALE, 32'h83, "unlock set");
        repeat (4) @(posedge sys_clk);
        rd_chk(ADDR_PRESCALE, 32'h3, "unlock expired");
        apb(1'b1, ADDR_PRESCALE, 32'h80);
        apb(1'b1, ADDR_PRESCALE, 32'h80);
        apb(1'b1, ADDR_PRESCALE, 32'h05);
        rd_chk(ADDR_PRESCALE, 32'h3, "late write");
        apb(1'b1, ADDR_PRESCALE, 32'h80);
        apb(1'b1, ADDR_PRESCALE, 32'h09);
        rd_chk(ADDR_PRESCALE, 32'h3, "reserved code");
        apb(1'b1, ADDR_PRESCALE, 32'h80);
        apb(1'b1, ADDR_PRESCALE, 32'h08);
        rd_chk(ADDR_PRESCALE, 32'h8, "max code");
    endtask
    task automatic t_rate();
        int n, bad, k;
        n = 0;
        bad = 0;
        k = 0;
        apb(1'b1, ADDR_PRESCALE, 32'h80);
        apb(1'b1, ADDR_PRESCALE, 32'h02);
        rdv = 32'h10;
        while (rdv[STAT_BUSY_BIT] !== 1'b0 && k < 200)
        begin
            apb(1'b0, ADDR_STATUS, 32'h0);
            k++;
        end
        `CHK("active div", 4'h2, rdv[STAT_DIV_LSB +: 4])
        `CHK("switch busy", 1'b0, rdv[STAT_BUSY_BIT])
        @(posedge sys_clk);
        sinkClear <= 1'b1;
        @(posedge sys_clk);
        sinkClear <= 1'b0;
        repeat (64)
        begin
            @(posedge sys_clk);
            #1;
            if (ioClkEn === 1'b1)
                n++;
            if ({adcClkEn, cpuClkEn, flashClkEn} !== {3{ioClkEn}})
                bad++;
        end
        `CHK("enable pulses", 16, n)
        `CHK("domain mismatch", 0, bad)
        `CHK("pin edges", 16, sinkEdges)
        `CHK("gpio override", 1'b1, gpioOverride)
    endtask
    task automatic t_trim();
        apb(1'b1, ADDR_TRIM, 32'h7F);
        #1;
        `CHK("band 7F", 1'b0, trimBandBit)
        `CHK("fine 7F", 7'h7F, trimFineBits)
        apb(1'b1, ADDR_TRIM, 32'h80);
        #1;
        `CHK("band 80", 1'b1, trimBandBit)
        `CHK("fine 80", 7'h00, trimFineBits)
        rd_chk(ADDR_TRIM, 32'h80, "trim read");
    endtask
    task automatic t_unmapped();
        apb(1'b0, 8'h3C, 32'h0);
        `CHK("slverr", 1'b1, errv)
        `CHK("unmapped data", 32'h0, rdv)
    endtask
    initial
    begin
        t_decode();
        t_unlock();
        t_rate();
        t_trim();
        t_unmapped();
        end_of_test();
    end
endmodule
